/* File: rtl/ddecp_port.sv */
// Drive-side command sequencer for the event command port.
`timescale 1ns/1ps
`default_nettype none
module ddecp_port (
    input wire logic clk,
    input wire logic nrst,
    input wire logic event_in,
    input wire logic ack_in,
    input wire logic [7:0] bus_in,
    output logic [7:0] bus_out,
    output logic bus_oe,
    output ddecp_pkg::ddecp_req_t req,
    output logic intr_req,
    output logic [7:0] head_reg,
    output logic [7:0] op_reg,
    output logic op_start,
    input wire logic op_done,
    input wire logic [7:0] status_in,
    input wire logic diag_event,
    input wire logic [7:0] diag_code
);
    import ddecp_pkg::*;

    // ==========================================================
    // Input synchronisers.
    logic [2:0] ev_sync_reg;
    logic [2:0] ack_sync_reg;
    logic ev_reg;
    logic ack_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ev_sync_reg <= 3'h0;
            ack_sync_reg <= 3'h0;
            ev_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            ev_sync_reg <= {ev_sync_reg[1:0], event_in};
            ack_sync_reg <= {ack_sync_reg[1:0], ack_in};
            if (ev_sync_reg[1] == ev_sync_reg[2]) begin
                ev_reg <= ev_sync_reg[2];
            end
            if (ack_sync_reg[1] == ack_sync_reg[2]) begin
                ack_reg <= ack_sync_reg[2];
            end
        end
    end

    // ==========================================================
    // Command sequencer.
    ddecp_state_t state_reg;
    ddecp_state_t ret_reg;
    logic [7:0] esc_reg;
    logic [7:0] diag_reg;
    logic exec_done;
    logic intr_en_reg;
    logic [3:0] cnt_reg;
    logic op_started_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            ret_reg <= ST_IDLE;
            op_reg <= 8'h00;
            head_reg <= 8'h00;
            esc_reg <= 8'h00;
            intr_en_reg <= 1'b0;
            cnt_reg <= 4'h0;
            op_started_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (ev_reg) begin
                        state_reg <= ST_EVBYTE;
                    end
                end
                ST_EVBYTE: begin
                    if (ack_reg) begin
                        op_reg <= bus_in;
                        intr_en_reg <= bus_in[BIT_INTR];
                        esc_reg <= 8'h00;
                        ret_reg <= ST_EXEC;
                        if (bus_in[BIT_HEAD]) begin
                            state_reg <= ST_WAIT;
                            ret_reg <= ST_HEAD;
                        end else if (bus_in[BIT_ESCAPE]) begin
                            state_reg <= ST_WAIT;
                            ret_reg <= ST_ESC;
                        end else begin
                            state_reg <= ST_WAIT;
                        end
                    end
                end
                ST_HEAD: begin
                    if (ack_reg) begin
                        head_reg <= bus_in;
                        state_reg <= ST_WAIT;
                        ret_reg <= op_reg[BIT_ESCAPE] ? ST_ESC : ST_EXEC;
                    end
                end
                ST_ESC: begin
                    if (ack_reg) begin
                        esc_reg <= bus_in;
                        state_reg <= ST_WAIT;
                        ret_reg <= ST_EXEC;
                    end
                end
                ST_WAIT: begin
                    if (!ack_reg) begin
                        state_reg <= ret_reg;
                        cnt_reg <= 4'h0;
                        op_started_reg <= 1'b0;
                    end
                end
                ST_EXEC: begin
                    op_started_reg <= 1'b1;
                    if (cnt_reg != EXEC_CYC_W) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (exec_done) begin
                        state_reg <= ST_STAT;
                    end
                end
                ST_STAT: begin
                    if (ack_reg) begin
                        ret_reg <= ST_IDLE;
                        state_reg <= ST_WAIT;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign op_start = (state_reg == ST_EXEC) && !op_started_reg;

    // Execution ends once the minimum time has run and the work reports done.
    // The status byte is loaded then, so it stands for the whole request.
    assign exec_done = (state_reg == ST_EXEC) && op_started_reg && op_done
        && (cnt_reg == EXEC_CYC_W);

    // ==========================================================
    // Diagnostic record.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            diag_reg <= DIAG_INIT;
        end else if (diag_event) begin
            diag_reg <= diag_code;
        end
    end

    // ==========================================================
    // Bus side and request strobe.
    logic diag_sel;
    assign diag_sel = esc_reg[BIT_DIAG];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_out <= 8'h00;
        end else if (exec_done) begin
            bus_out <= diag_sel ? diag_reg : status_in;
        end
    end

    always_comb begin
        req.ready = 1'b0;
        req.addr = ADDR_EVENT;
        req.dir = DIR_FROM_ADAPTER;
        unique case (state_reg)
            ST_EVBYTE: begin
                req.ready = 1'b1;
                req.addr = ADDR_EVENT;
            end
            ST_HEAD: begin
                req.ready = 1'b1;
                req.addr = ADDR_HEAD;
            end
            ST_ESC: begin
                req.ready = 1'b1;
                req.addr = ADDR_ESCAPE;
            end
            ST_STAT: begin
                req.ready = 1'b1;
                req.dir = DIR_TO_ADAPTER;
                req.addr = diag_sel ? ADDR_DETAIL : ADDR_STATUS;
            end
            default: begin
                req.ready = 1'b0;
            end
        endcase
    end
    assign bus_oe = (state_reg == ST_STAT);

    // Interrupt is not gated by any select input.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            intr_req <= 1'b0;
        end else if (state_reg == ST_STAT && intr_en_reg) begin
            intr_req <= 1'b1;
        end else if (state_reg == ST_EVBYTE) begin
            intr_req <= 1'b0;
        end
    end

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    AST_REQ_EVBYTE: assert property (
        (state_reg == ST_IDLE && ev_reg) |=> req.ready
            && req.addr == ADDR_EVENT && req.dir == DIR_FROM_ADAPTER)
        else $error("Event byte not requested after event.");
    AST_HEAD_REQ: assert property (
        (state_reg == ST_EVBYTE && ack_reg && bus_in[BIT_HEAD])
            |=> ret_reg == ST_HEAD)
        else $error("Head byte not scheduled.");
    AST_NO_SELF_START: assert property (
        (state_reg == ST_IDLE && !ev_reg) |=> state_reg == ST_IDLE)
        else $error("Dialogue started without event.");
    AST_EXEC_AFTER_PARAMS: assert property (
        op_start |-> $past(state_reg) == ST_WAIT)
        else $error("Execution began before parameters.");
    AST_STAT_DIR: assert property (
        bus_oe |-> req.dir == DIR_TO_ADAPTER)
        else $error("Drive drives bus with wrong direction.");
    AST_IDLE_AFTER_STAT: assert property (
        (state_reg == ST_STAT && ack_reg) |=> ret_reg == ST_IDLE)
        else $error("Sequencer does not return idle.");
    AST_INTR: assert property (
        (state_reg == ST_STAT && intr_en_reg) |=> intr_req)
        else $error("Interrupt not raised.");
    AST_DIAG: assert property (
        diag_event |=> diag_reg == $past(diag_code))
        else $error("Diagnostic record not stored.");
    AST_STAT_HELD: assert property (
        (state_reg == ST_STAT && $past(state_reg) == ST_STAT)
            |-> $stable(bus_out))
        else $error("Status byte changed while offered.");
    COV_EVENT: cover property (state_reg == ST_EVBYTE && ack_reg);
    COV_HEAD: cover property (state_reg == ST_HEAD && ack_reg);
    COV_ESC: cover property (state_reg == ST_ESC && ack_reg);
    COV_STAT: cover property (state_reg == ST_STAT && ack_reg);
endmodule
`default_nettype wire

/* File: rtl/ddecp_pkg.sv */
// Package with constants and types for the disk drive event command port.
package ddecp_pkg;
    localparam logic [2:0] ADDR_EVENT = 3'h7;
    localparam logic [2:0] ADDR_ESCAPE = 3'h0;
    localparam logic [2:0] ADDR_HEAD = 3'h5;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    localparam logic [2:0] ADDR_DETAIL = 3'h2;
    localparam int BIT_INTR = 1;
    localparam int BIT_HEAD = 5;
    localparam int BIT_ESCAPE = 7;
    localparam int BIT_DIAG = 0;
    localparam logic DIR_FROM_ADAPTER = 1'b1;
    localparam logic DIR_TO_ADAPTER = 1'b0;
    localparam int EXEC_NS = 80;
    localparam int CLK_NS = 8;
    localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] EXEC_CYC_W = 4'(EXEC_CYC);
    localparam logic [7:0] DIAG_INIT = 8'h00;

    typedef struct packed {
        logic ready;
        logic [2:0] addr;
        logic dir;
    } ddecp_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EVBYTE = 3'b001,
        ST_HEAD = 3'b010,
        ST_ESC = 3'b011,
        ST_EXEC = 3'b100,
        ST_STAT = 3'b101,
        ST_WAIT = 3'b110
    } ddecp_state_t;
endpackage

/* File: testbench/ddecp_adapter.sv */
// Behavioural adapter model that answers the drive's byte requests.
`timescale 1ns/1ps
`default_nettype none
module ddecp_adapter (
    input wire logic clk,
    input wire logic nrst,
    input wire ddecp_pkg::ddecp_req_t req,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe,
    input wire logic go,
    input wire logic [7:0] cmd_byte,
    input wire logic [7:0] head_byte,
    input wire logic [7:0] esc_byte,
    input wire logic [3:0] delay,
    output logic event_in,
    output logic ack_in,
    output logic [7:0] bus_in,
    output logic [7:0] got_byte
);
    import ddecp_pkg::*;
    logic drv_reg;
    logic [7:0] data_reg;
    logic [7:0] last_reg;
    logic [3:0] wait_reg;
    // ==========================================================
    // Bus level: a released bus shows the inverse of its last level.
    assign bus_in = bus_oe ? bus_out
        : (drv_reg ? data_reg : ~last_reg);
    // ==========================================================
    // Handshake: answer after delay cycles, hold until ready drops.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            event_in <= 1'b0;
            ack_in <= 1'b0;
            drv_reg <= 1'b0;
            data_reg <= 8'h00;
            last_reg <= 8'h00;
            wait_reg <= 4'h0;
            got_byte <= 8'h00;
        end else begin
            last_reg <= bus_in;
            if (go) begin
                event_in <= 1'b1;
            end
            if (ack_in && !req.ready) begin
                ack_in <= 1'b0;
                drv_reg <= 1'b0;
                event_in <= 1'b0;
                wait_reg <= 4'h0;
            end else if (req.ready && !ack_in) begin
                if (wait_reg < delay) begin
                    wait_reg <= wait_reg + 4'h1;
                end else if (req.dir == DIR_FROM_ADAPTER) begin
                    drv_reg <= 1'b1;
                    data_reg <= (req.addr == ADDR_HEAD) ? head_byte
                        : (req.addr == ADDR_ESCAPE) ? esc_byte
                        : cmd_byte;
                    ack_in <= 1'b1;
                end else begin
                    got_byte <= bus_in;
                    ack_in <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/test_disk_drive_event_command_port.sv */
// Self-checking testbench for the drive-side event command port.
`timescale 1ns/1ps
`default_nettype none
module test_disk_drive_event_command_port;
    import ddecp_pkg::*;
    logic clk, nrst, go, op_done, diag_event, event_in, ack_in;
    logic bus_oe, intr_req, op_start, rdy_d;
    logic [7:0] cmd, head, esc, status_in, diag_code, bus_in, bus_out;
    logic [7:0] head_reg, op_reg, got;
    logic [3:0] delay;
    ddecp_req_t req;
    logic [31:0] seq;
    int n_ent, n_mismatch, cmp_count, cycles, exec_cnt;
    ddecp_port DUT (.clk(clk), .nrst(nrst), .event_in(event_in),
        .ack_in(ack_in), .bus_in(bus_in), .bus_out(bus_out),
        .bus_oe(bus_oe), .req(req), .intr_req(intr_req),
        .head_reg(head_reg), .op_reg(op_reg), .op_start(op_start),
        .op_done(op_done), .status_in(status_in),
        .diag_event(diag_event), .diag_code(diag_code));
    ddecp_adapter adapter (.clk(clk), .nrst(nrst), .req(req),
        .bus_out(bus_out), .bus_oe(bus_oe), .go(go), .cmd_byte(cmd),
        .head_byte(head), .esc_byte(esc), .delay(delay),
        .event_in(event_in), .ack_in(ack_in), .bus_in(bus_in),
        .got_byte(got));
    // ==========================================================
    // Logger, execution model and timeout.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        rdy_d <= req.ready;
        if (req.ready && !rdy_d) begin
            seq <= {seq[26:0], 1'b1, req.addr, req.dir};
            n_ent <= n_ent + 1;
        end
        if (op_start) begin
            seq <= {seq[26:0], 5'h0a};
            n_ent <= n_ent + 1;
            op_done <= 1'b0;
            exec_cnt <= 12;
        end else if (exec_cnt > 0) begin
            exec_cnt <= exec_cnt - 1;
            op_done <= (exec_cnt == 1);
        end
        if (cycles == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [7:0] c, h, e, input logic [3:0] d,
        input int n);
        int k;
        @(posedge clk);
        cmd <= c;
        head <= h;
        esc <= e;
        delay <= d;
        seq <= 32'h0;
        n_ent <= 0;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        while (k < 600 && !(n_ent == n && !req.ready && !ack_in)) begin
            @(negedge clk);
            k++;
        end
        check(32'(k == 600), 32'h0);
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_plain();
        run(8'h00, 8'h11, 8'h00, 4'h0, 3);
        check(seq, 32'({5'h1f, 5'h0a, 5'h1e}));
        check(32'(got), 32'h96);
        check(32'(op_reg), 32'h00);
        check(32'(intr_req), 32'h0);
    endtask
    task automatic t_head_intr();
        run(8'h22, 8'h3c, 8'h00, 4'h1, 4);
        check(seq, 32'({5'h1f, 5'h1b, 5'h0a, 5'h1e}));
        check(32'(head_reg), 32'h3c);
        check(32'(op_reg), 32'h22);
        check(32'(intr_req), 32'h1);
    endtask
    task automatic t_escape_diag();
        @(posedge clk);
        diag_event <= 1'b1;
        diag_code <= 8'h5a;
        @(posedge clk);
        diag_event <= 1'b0;
        run(8'ha0, 8'h07, 8'h01, 4'h9, 5);
        check(seq, 32'({5'h1f, 5'h1b, 5'h11, 5'h0a, 5'h14}));
        check(32'(got), 32'h5a);
        check(32'(head_reg), 32'h07);
        check(32'(intr_req), 32'h0);
    endtask
    task automatic t_escape_only();
        run(8'h80, 8'h44, 8'h00, 4'h2, 4);
        check(seq, 32'({5'h1f, 5'h11, 5'h0a, 5'h1e}));
        check(32'(got), 32'h96);
        check(32'(head_reg), 32'h07);
        check(32'(op_reg), 32'h80);
        check(32'(intr_req), 32'h0);
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {nrst, go, op_done, diag_event, rdy_d} = 5'h00;
        {cmd, head, esc, diag_code, delay} = 36'h0;
        status_in = 8'h96;
        seq = 32'h0;
        {n_ent, n_mismatch, cmp_count, cycles, exec_cnt} = 160'h0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_plain();
        t_head_intr();
        t_escape_diag();
        t_escape_only();
        wrap_up();
    end
endmodule
`default_nettype wire
